// ---- core/cfb_branch_unit.sv ----
// Purpose: executes four flag-tested relative branches of an 8-bit core
// Assumes: instr_valid/instr presented synchronous to clk_sys
// Notes: status flags leave through a register untouched; a taken branch costs one extra cycle
`timescale 1ns/1ps
module cfb_branch_unit
   import cfb_pkg::*;
#(
   parameter int PC_W = CFB_PC_W
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire cfb_instr_t instr,
   input wire logic [7:0] sreg_in,
   output logic instr_ready,
   output logic [PC_W-1:0] pc,
   output logic [7:0] sreg_out,
   output logic branch_taken
);
   cfb_state_t state;
   cfb_state_t next_state;
   logic [PC_W-1:0] next_pc;
   logic [PC_W-1:0] target;
   logic [PC_W-1:0] ofs_ext;
   logic [1:0] stall_cnt;
   logic [1:0] next_stall_cnt;
   // longest legal stall after an accepted branch
   localparam logic [1:0] STALL_MAX = 2'(CFB_CYC_TAKEN - CFB_CYC_NOT_TAKEN);
   // farthest distance a signed offset can move the pc
   localparam logic [PC_W-1:0] REACH = PC_W'(2 ** (CFB_OFS_W - 1));
   wire flag_t = sreg_in[CFB_BIT_T];
   wire flag_v = sreg_in[CFB_BIT_V];
   wire flag_h = sreg_in[CFB_BIT_H];
   wire is_branch = instr.op != CFB_OP_NONE;
   wire cond_tc = instr.op == CFB_OP_BRANCH_TRANSFER_BIT_CLEAR && !flag_t;
   wire cond_ts = instr.op == CFB_OP_BRANCH_TRANSFER_BIT_SET && flag_t;
   wire cond_vs = instr.op == CFB_OP_BRANCH_OVERFLOW_SET && flag_v;
   wire cond_hc = instr.op == CFB_OP_BRANCH_HALF_CARRY_CLEAR && !flag_h;
   wire cond = cond_tc | cond_ts | cond_vs | cond_hc;
   wire accept = instr_valid && state == CFB_ST_EXEC;
   wire take = accept && is_branch && cond;

   // sign extension of the offset
   assign ofs_ext = {{(PC_W-CFB_OFS_W){instr.offset[CFB_OFS_W-1]}}, instr.offset};
   assign target = pc + ofs_ext + {{(PC_W-1){1'b0}}, 1'b1};
   assign instr_ready = state == CFB_ST_EXEC;
   // stall cycles counted since the last ready cycle, saturating at three
   assign next_stall_cnt = instr_ready ? 2'h0
      : (stall_cnt == 2'h3) ? stall_cnt : stall_cnt + 2'h1;

   always_comb
   begin
      next_state = state;
      next_pc = pc;
      case (state)
         CFB_ST_EXEC:
         begin
            if (accept && is_branch && cond)
            begin
               next_pc = target;
               next_state = CFB_ST_TAKEN;
            end
            else if (accept)
            begin
               next_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
            end
         end
         CFB_ST_TAKEN:
         begin
            next_state = CFB_ST_EXEC;
         end
         default:
         begin
            next_state = CFB_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= CFB_ST_EXEC;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc <= CFB_PC_RESET[PC_W-1:0];
      end
      else
      begin
         pc <= next_pc;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         branch_taken <= 1'b0;
      end
      else
      begin
         branch_taken <= take;
      end
   end

   // flags are never written by these branches, only registered on the way out
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sreg_out <= CFB_SREG_RESET;
      end
      else
      begin
         sreg_out <= sreg_in;
      end
   end

   // helper count of stall cycles, read only by the stall bound check
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stall_cnt <= 2'h0;
      end
      else
      begin
         stall_cnt <= next_stall_cnt;
      end
   end

   // outcome of each branch kind, taken or falling through
   a_tclear_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_TRANSFER_BIT_CLEAR && !flag_t)
      |=> branch_taken && !instr_ready)
      else $error("transfer bit clear branch not taken");
   a_tclear_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_TRANSFER_BIT_CLEAR && flag_t)
      |=> !branch_taken && pc == $past(pc) + 1'b1)
      else $error("transfer bit clear branch did not fall through");
   a_overflow_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_OVERFLOW_SET && flag_v)
      |=> branch_taken && !instr_ready)
      else $error("overflow branch not taken");
   a_overflow_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_OVERFLOW_SET && !flag_v)
      |=> pc == $past(pc) + 1'b1 && !branch_taken)
      else $error("overflow branch did not fall through");
   a_hcarry_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_HALF_CARRY_CLEAR && !flag_h)
      |=> branch_taken && !instr_ready)
      else $error("half carry clear branch not taken");
   a_hcarry_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_HALF_CARRY_CLEAR && flag_h)
      |=> !branch_taken && instr_ready && pc == $past(pc) + 1'b1)
      else $error("half carry clear branch did not fall through");
   a_tset_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_TRANSFER_BIT_SET && flag_t)
      |=> branch_taken && !instr_ready)
      else $error("transfer bit set branch not taken");
   a_tset_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_BRANCH_TRANSFER_BIT_SET && !flag_t)
      |=> !branch_taken && pc == $past(pc) + 1'b1)
      else $error("transfer bit set branch did not fall through");
   a_none_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && instr.op == CFB_OP_NONE)
      |=> pc == $past(pc) + 1'b1 && !branch_taken)
      else $error("plain step did not advance by one");
   a_idle_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (instr_ready && !instr_valid)
      |=> pc == $past(pc) && !branch_taken)
      else $error("pc moved with no instruction");

   // where a taken branch lands
   a_taken_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && cond)
      |=> pc == $past(pc) + PC_W'($signed($past(instr.offset))) + 1'b1)
      else $error("taken branch target wrong");
   a_backward_reach: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && cond && instr.offset[CFB_OFS_W-1])
      |=> ($past(pc) - pc) < REACH)
      else $error("negative offset did not go backward");
   a_forward_reach: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && cond && !instr.offset[CFB_OFS_W-1])
      |=> (pc - $past(pc)) != '0 && (pc - $past(pc)) <= REACH)
      else $error("positive offset did not go forward");

   // cycle cost: one when not taken, two when taken
   a_taken_two_cyc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && cond)
      |=> !instr_ready ##1 instr_ready)
      else $error("taken branch not two cycles");
   a_not_taken_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (accept && !cond)
      |=> instr_ready)
      else $error("untaken branch stalled");
   a_stall_holds_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !instr_ready
      |=> pc == $past(pc) && !branch_taken)
      else $error("pc moved during the stall cycle");
   a_stall_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stall_cnt <= STALL_MAX)
      else $error("stall longer than one cycle");
   a_taken_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      branch_taken
      |=> !branch_taken)
      else $error("taken pulse longer than one cycle");

   // flags pass through unchanged
   a_flags_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n)
      |-> sreg_out == $past(sreg_in))
      else $error("flags changed");
endmodule

// ---- inc/cfb_pkg.sv ----
// Purpose: shared types and constants for the conditional flag branch unit
// Assumes: one 100 MHz core clock, program counter in instruction words
// Notes: branch codes are the unit's own select encoding
package cfb_pkg;
   localparam int CFB_PC_W = 16;
   localparam int CFB_OFS_W = 7;
   localparam logic [15:0] CFB_PC_RESET = 16'h0000;
   localparam logic [7:0] CFB_SREG_RESET = 8'h00;
   // status register bit positions
   localparam int CFB_BIT_H = 5;
   localparam int CFB_BIT_T = 6;
   localparam int CFB_BIT_V = 3;
   // cycles used by a branch
   localparam int CFB_CYC_NOT_TAKEN = 1;
   localparam int CFB_CYC_TAKEN = 2;

   typedef enum logic [2:0] {
      CFB_OP_NONE = 3'b000,
      CFB_OP_BRANCH_TRANSFER_BIT_CLEAR = 3'b001,
      CFB_OP_BRANCH_TRANSFER_BIT_SET = 3'b010,
      CFB_OP_BRANCH_OVERFLOW_SET = 3'b011,
      CFB_OP_BRANCH_HALF_CARRY_CLEAR = 3'b100
   } cfb_op_t;

   typedef enum logic [0:0] {
      CFB_ST_EXEC = 1'b0,
      CFB_ST_TAKEN = 1'b1
   } cfb_state_t;

   typedef struct packed {
      cfb_op_t op;
      logic [6:0] offset;
   } cfb_instr_t;
endpackage

// ---- verif/cfb_branch_unit_tb.sv ----
// Purpose: random self-checking bench for the flag branch unit
// Assumes: pc, ready and taken settle 1 ns after the rising edge
// Notes: the model tracks pc and the bubble that follows a taken branch
`timescale 1ns/1ps
module cfb_branch_unit_tb;
   import cfb_pkg::*;
   logic clk_sys = 0;
   logic rst_n = 0;
   logic instr_valid = 0;
   cfb_instr_t instr = '0;
   logic [7:0] sreg_in = 8'h00;
   logic instr_ready;
   logic [15:0] pc;
   logic [7:0] sreg_out;
   logic branch_taken;
   logic [15:0] e_pc;
   logic e_rdy;
   logic e_tk;
   logic [7:0] e_sreg;
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'h1cb3;
   cfb_branch_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr(instr), .sreg_in(sreg_in), .instr_ready(instr_ready), .pc(pc),
      .sreg_out(sreg_out), .branch_taken(branch_taken));
   initial forever #5 clk_sys = ~clk_sys;
   function automatic logic cond_f(cfb_op_t op, logic [7:0] s);
      case (op)
         CFB_OP_BRANCH_TRANSFER_BIT_CLEAR: return !s[CFB_BIT_T];
         CFB_OP_BRANCH_TRANSFER_BIT_SET: return s[CFB_BIT_T];
         CFB_OP_BRANCH_OVERFLOW_SET: return s[CFB_BIT_V];
         CFB_OP_BRANCH_HALF_CARRY_CLEAR: return !s[CFB_BIT_H];
         default: return 1'b0;
      endcase
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      #1 rst_n = 1;
      e_pc = CFB_PC_RESET;
      e_rdy = 1'b1;
      e_tk = 1'b0;
      e_sreg = sreg_in;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk_sys);
         #1;
         chk(pc, e_pc);
         chk({15'h0, branch_taken}, {15'h0, e_tk});
         chk({15'h0, instr_ready}, {15'h0, e_rdy});
         chk({8'h00, sreg_out}, {8'h00, e_sreg});
         instr_valid = 1'($random(seed));
         instr.op = cfb_op_t'(3'(($random(seed) & 32'h7fff) % 5));
         // extreme offsets mixed into the random ones
         instr.offset = (i % 5 == 0) ? 7'h40 : (i % 5 == 1) ? 7'h3f : 7'($random(seed));
         sreg_in = 8'($random(seed));
         e_sreg = sreg_in;
         e_tk = instr_valid && e_rdy && cond_f(instr.op, sreg_in);
         if (instr_valid && e_rdy)
            e_pc = e_pc + 16'h0001 + (e_tk ? {{9{instr.offset[6]}}, instr.offset} : 16'h0000);
         e_rdy = !e_tk;
         if (i == 1500)
         begin
            // reset in mid-run, with the instruction just driven still pending
            rst_n = 1'b0;
            #1 chk(pc, CFB_PC_RESET);
            chk({15'h0, branch_taken}, 16'h0000);
            chk({15'h0, instr_ready}, 16'h0001);
            chk({8'h00, sreg_out}, {8'h00, CFB_SREG_RESET});
            repeat (2) @(posedge clk_sys);
            #1 rst_n = 1'b1;
            instr_valid = 1'b0;
            e_pc = CFB_PC_RESET;
            e_tk = 1'b0;
            e_rdy = 1'b1;
            $display("mid-run reset test done");
         end
      end
      $display("random branch test done");
      conclude();
   end
endmodule
